// >>> core/hbsc_pkg.sv
// What this block does
// - Chip select fall captures the host address
// - Chip select rise ends the cycle
// - Reset low initialises state, straps sampled
// - Byte order strap high: little endian
// - Width strap high: 32-bit, low: 16-bit
// - Bus mode strap high: multiplexed address/data
// - Straps latched at reset release, held
// - Multiplexed mode: bit-2 pin is latch strobe
// - Word aligned addresses, lowest line bit 2
`default_nettype none
package hbsc_pkg;

    // Data bus geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned HALF_W = 16;

    // Word address field: host address bits 15 down to 2
    localparam int unsigned ADDR_LSB = 2;
    localparam int unsigned ADDR_MSB = 15;
    localparam int unsigned ADDR_W = ADDR_MSB - ADDR_LSB + 1;
    localparam int unsigned ADDR_HI_W = ADDR_W - 1;

    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
    localparam logic CS_N_RST = 1'b1;
    localparam logic STROBE_RST = 1'b0;

    // Host lanes driven in each width mode
    localparam logic [DATA_W-1:0] LANES_32 = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] LANES_16 = 32'h0000_FFFF;

    // Access sequencer states
    typedef enum logic [1:0] {
        HBSC_IDLE,
        HBSC_RD_WAIT,
        HBSC_RD_DRIVE,
        HBSC_WR_HOLD
    } hbsc_state_e;

    // Reverses the byte order of a word
    function automatic logic [DATA_W-1:0] hbsc_swap32(input logic [DATA_W-1:0] w);
        hbsc_swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

endpackage
`default_nettype wire

// >>> core/hbsc_edge.sv
`timescale 1ns/1ps
`default_nettype none
module hbsc_edge #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Sampled level
    input wire logic sig,
    // Edge pulses
    output logic rise,
    output logic fall
);

    logic prev_q;
    logic prev_d;

    // Previous level, reset to the idle level of the line
    always_comb begin
        prev_d = rstn ? sig : RST_VAL;
    end

    always_ff @(posedge clk_sys) begin
        prev_q <= prev_d;
    end

    // Edge pulses from current and previous level
    assign rise = sig & ~prev_q;
    assign fall = ~sig & prev_q;

endmodule
`default_nettype wire

// >>> core/hbsc_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module hbsc_host_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Host bus control
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    // Host address lines 15..3 and the shared bit-2 pin
    input wire logic [hbsc_pkg::ADDR_HI_W-1:0] addr_hi,
    input wire logic addr_bit2_or_latch_strobe,
    // Host data lines
    input wire logic [hbsc_pkg::DATA_W-1:0] data_in,
    output logic [hbsc_pkg::DATA_W-1:0] data_out,
    output logic [hbsc_pkg::DATA_W-1:0] data_oe,
    // Configuration straps
    input wire logic byte_order_strap,
    input wire logic width_strap,
    input wire logic bus_mode_strap,
    // Latched configuration
    output logic cfg_little_endian,
    output logic cfg_bus32,
    output logic cfg_muxed,
    // Core request side
    output logic req_valid,
    output logic req_write,
    output logic [hbsc_pkg::ADDR_W-1:0] req_addr,
    output logic [hbsc_pkg::DATA_W-1:0] req_wdata,
    // Core read answer
    input wire logic rd_ack,
    input wire logic [hbsc_pkg::DATA_W-1:0] rd_data
);
    import hbsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture

    logic order_q;
    logic order_d;
    logic b32_q;
    logic b32_d;
    logic mux_q;
    logic mux_d;

    // Follow the straps while reset is low, freeze at release
    always_comb begin
        order_d = rstn ? order_q : byte_order_strap;
        b32_d = rstn ? b32_q : width_strap;
        mux_d = rstn ? mux_q : bus_mode_strap;
    end

    always_ff @(posedge clk_sys) begin
        order_q <= order_d;
        b32_q <= b32_d;
        mux_q <= mux_d;
    end

    assign cfg_little_endian = order_q;
    assign cfg_bus32 = b32_q;
    assign cfg_muxed = mux_q;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection

    logic cs_rise;
    logic cs_fall;
    logic stb_fall;

    hbsc_edge #(.RST_VAL(CS_N_RST)) u_cs_edge (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sig(cs_n),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    hbsc_edge #(.RST_VAL(STROBE_RST)) u_stb_edge (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sig(addr_bit2_or_latch_strobe),
        .rise(),
        .fall(stb_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address selection

    logic [ADDR_W-1:0] addr_now;
    logic [ADDR_W-1:0] mux_addr_q;
    logic [ADDR_W-1:0] mux_addr_d;

    // Multiplexed mode takes the address from the data lines at strobe fall
    always_comb begin
        mux_addr_d = mux_addr_q;
        if (!rstn) begin
            mux_addr_d = ADDR_RST;
        end else if (mux_q && stb_fall) begin
            mux_addr_d = data_in[ADDR_MSB:ADDR_LSB];
        end
    end

    always_ff @(posedge clk_sys) begin
        mux_addr_q <= mux_addr_d;
    end

    // Word address offered at chip select fall
    always_comb begin
        if (mux_q) begin
            addr_now = mux_addr_q;
        end else begin
            addr_now = {addr_hi, addr_bit2_or_latch_strobe};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte order mapping between host lanes and core words

    logic [DATA_W-1:0] rd_host;
    logic [DATA_W-1:0] wr_now;
    logic [DATA_W-1:0] wr_word32;
    logic [DATA_W-1:0] wr_word16;
    logic [DATA_W-1:0] cache_q;
    logic [DATA_W-1:0] wlat_q;

    // Big endian swaps the bytes, little endian passes them straight
    always_comb begin
        rd_host = order_q ? rd_data : hbsc_swap32(rd_data);
        wr_now = wr_n ? wlat_q : data_in;
        wr_word32 = order_q ? wr_now : hbsc_swap32(wr_now);
        wr_word16 = order_q ? {wr_now[HALF_W-1:0], cache_q[HALF_W-1:0]}
                         : hbsc_swap32({wr_now[HALF_W-1:0], cache_q[HALF_W-1:0]});
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer

    hbsc_state_e st_q;
    hbsc_state_e st_d;
    logic half_q;
    logic half_d;
    logic wseen_q;
    logic wseen_d;
    logic oe_q;
    logic oe_d;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] dout_d;
    logic [DATA_W-1:0] cache_d;
    logic [DATA_W-1:0] wlat_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic req_q;
    logic req_d;
    logic rw_q;
    logic rw_d;
    logic [ADDR_W-1:0] raddr_q;
    logic [ADDR_W-1:0] raddr_d;
    logic [DATA_W-1:0] wdat_q;
    logic [DATA_W-1:0] wdat_d;

    // Next values of the sequencer
    always_comb begin
        st_d = st_q;
        half_d = half_q;
        wseen_d = wseen_q;
        oe_d = oe_q;
        dout_d = dout_q;
        cache_d = cache_q;
        wlat_d = wlat_q;
        addr_d = addr_q;
        req_d = 1'b0;
        rw_d = rw_q;
        raddr_d = raddr_q;
        wdat_d = wdat_q;
        // A finished cycle moves to the other half in 16-bit mode
        if (cs_rise && st_q != HBSC_IDLE) begin
            st_d = HBSC_IDLE;
            oe_d = 1'b0;
            half_d = b32_q ? 1'b0 : ~half_q;
        end
        case (st_q)
            HBSC_IDLE: begin
                if (cs_fall) begin
                    addr_d = addr_now;
                    wseen_d = 1'b0;
                    if (!rd_n) begin
                        if (b32_q || !half_q) begin
                            req_d = 1'b1;
                            rw_d = 1'b0;
                            raddr_d = addr_now;
                            st_d = HBSC_RD_WAIT;
                        end else begin
                            dout_d = {{HALF_W{1'b0}}, cache_q[DATA_W-1:HALF_W]};
                            oe_d = 1'b1;
                            st_d = HBSC_RD_DRIVE;
                        end
                    end else begin
                        st_d = HBSC_WR_HOLD;
                    end
                end
            end
            HBSC_RD_WAIT: begin
                if (rd_ack && !cs_rise) begin
                    cache_d = rd_host;
                    dout_d = b32_q ? rd_host : {{HALF_W{1'b0}}, rd_host[HALF_W-1:0]};
                    oe_d = 1'b1;
                    st_d = HBSC_RD_DRIVE;
                end
            end
            HBSC_RD_DRIVE: begin
                // Data stands until chip select rises
            end
            HBSC_WR_HOLD: begin
                if (!wr_n) begin
                    wlat_d = data_in;
                    wseen_d = 1'b1;
                end
                if (cs_rise && (wseen_q || !wr_n)) begin
                    if (b32_q) begin
                        req_d = 1'b1;
                        rw_d = 1'b1;
                        raddr_d = addr_q;
                        wdat_d = wr_word32;
                    end else if (!half_q) begin
                        cache_d = {cache_q[DATA_W-1:HALF_W], wr_now[HALF_W-1:0]};
                    end else begin
                        req_d = 1'b1;
                        rw_d = 1'b1;
                        raddr_d = addr_q;
                        wdat_d = wr_word16;
                    end
                end
            end
            default: begin
                st_d = HBSC_IDLE;
            end
        endcase
        // Synchronous reset returns everything to its initial value
        if (!rstn) begin
            st_d = HBSC_IDLE;
            half_d = 1'b0;
            wseen_d = 1'b0;
            oe_d = 1'b0;
            dout_d = DATA_RST;
            cache_d = DATA_RST;
            wlat_d = DATA_RST;
            addr_d = ADDR_RST;
            req_d = 1'b0;
            rw_d = 1'b0;
            raddr_d = ADDR_RST;
            wdat_d = DATA_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_q <= st_d;
        half_q <= half_d;
        wseen_q <= wseen_d;
        oe_q <= oe_d;
        dout_q <= dout_d;
        cache_q <= cache_d;
        wlat_q <= wlat_d;
        addr_q <= addr_d;
        req_q <= req_d;
        rw_q <= rw_d;
        raddr_q <= raddr_d;
        wdat_q <= wdat_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Drive stops in the same cycle chip select goes high
    assign data_oe = (oe_q && !cs_n) ? (b32_q ? LANES_32 : LANES_16) : DATA_RST;
    assign data_out = dout_q;
    assign req_valid = req_q;
    assign req_write = rw_q;
    assign req_addr = raddr_q;
    assign req_wdata = wdat_q;

endmodule
`default_nettype wire

// >>> tb/hbsc_host_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hbsc_host_port_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Host bus
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic [31:0] data_out,
    input wire logic [31:0] data_oe,
    // Straps and latched configuration
    input wire logic byte_order_strap,
    input wire logic width_strap,
    input wire logic bus_mode_strap,
    input wire logic cfg_little_endian,
    input wire logic cfg_bus32,
    input wire logic cfg_muxed,
    // Core side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic rd_ack,
    input wire logic [31:0] rd_data
);
    logic [31:0] rd_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Core word of the last cycle, for the byte order checks
    always_ff @(posedge clk_sys) begin
        rd_q <= rd_data;
    end
    ////////////////////////////////////////////////////////////////
    oe_cs_off_a: assert property (cs_n |-> data_oe == 32'h0)
        else $error("Data lanes driven while deselected");
    oe_lanes_a: assert property (!cfg_bus32 |-> data_oe[31:16] == 16'h0)
        else $error("Upper lanes driven in narrow mode");
    cfg_hold_a: assert property ($past(rstn) |-> $stable({cfg_little_endian, cfg_bus32, cfg_muxed}))
        else $error("Configuration moved outside reset");
    cfg_latch_a: assert property ($rose(rstn) |->
        {cfg_little_endian, cfg_bus32, cfg_muxed} == $past({byte_order_strap, width_strap, bus_mode_strap}))
        else $error("Configuration not taken at reset release");
    rd_req_a: assert property (cfg_bus32 && $fell(cs_n) && !rd_n |=> req_valid && !req_write)
        else $error("Read cycle gave no core read");
    wr_req_a: assert property (req_valid && req_write |-> $past(cs_n) && !$past(cs_n, 2))
        else $error("Core write not right after cycle end");
    little_data_a: assert property (rd_ack && !cs_n && cfg_bus32 && cfg_little_endian |=> data_out == rd_q)
        else $error("Little endian read data wrong");
    be_data_a: assert property (rd_ack && !cs_n && cfg_bus32 && !cfg_little_endian
        |=> data_out == {rd_q[7:0], rd_q[15:8], rd_q[23:16], rd_q[31:24]})
        else $error("Big endian read data wrong");
    // Main scenarios
    rd_seen_c: cover property (req_valid && !req_write && cfg_muxed);
    wr_seen_c: cover property (req_valid && req_write && !cfg_bus32);
    oe_seen_c: cover property (data_oe[0] && !cfg_little_endian);
endmodule
bind hbsc_host_port hbsc_host_port_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n),
    .data_out(data_out), .data_oe(data_oe), .byte_order_strap(byte_order_strap), .width_strap(width_strap),
    .bus_mode_strap(bus_mode_strap), .cfg_little_endian(cfg_little_endian), .cfg_bus32(cfg_bus32),
    .cfg_muxed(cfg_muxed), .req_valid(req_valid), .req_write(req_write), .rd_ack(rd_ack), .rd_data(rd_data));
`default_nettype wire

// >>> tb/hbsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbsc_host_model (
    // Clock and bus mode
    input wire logic clk_sys,
    input wire logic muxed,
    // Host bus
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [12:0] addr_hi,
    output logic strobe,
    output logic [31:0] data_in,
    // Device answer
    input wire logic [31:0] data_out,
    input wire logic [31:0] data_oe
);
    // Idle bus
    initial begin
        {cs_n, rd_n, wr_n, strobe} = 4'hE;
        addr_hi = 13'h0000;
        data_in = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////
    // Opens a cycle; in multiplexed mode the address goes first through the latch
    task automatic start(input logic [13:0] a, input logic rd);
        @(negedge clk_sys);
        if (muxed) begin
            data_in[15:2] = a;
            strobe = 1'b1;
            @(negedge clk_sys);
            strobe = 1'b0;
            @(negedge clk_sys);
            data_in = ~data_in;
            addr_hi = ~a[13:1]; // Unused lines carry junk
        end else begin
            {addr_hi, strobe} = a;
        end
        cs_n = 1'b0;
        rd_n = !rd;
    endtask
    // Read cycle, ended by the host once the lanes are driven
    task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [31:0] oe);
        start(a, 1'b1);
        for (int i = 0; i < 40 && data_oe[0] !== 1'b1; i++) @(negedge clk_sys);
        d = data_out;
        oe = data_oe;
        cs_n = 1'b1;
        rd_n = 1'b1;
    endtask
    // Write cycle with one strobe pulse
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        start(a, 1'b0);
        @(negedge clk_sys);
        wr_n = 1'b0;
        data_in = d;
        @(negedge clk_sys);
        wr_n = 1'b1;
        @(negedge clk_sys);
        cs_n = 1'b1;
        data_in = ~d; // Released lines do not keep the last value
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_hbsc_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hbsc_host_port;
    import hbsc_pkg::*;
    localparam logic [31:0] CORE_WORD = 32'hA1B2_C3D4;
    localparam logic [31:0] CORE_SWAP = 32'hD4C3_B2A1;
    localparam logic [31:0] HOST_WORD = 32'h5A6B_7C8D;
    localparam logic [31:0] HOST_SWAP = 32'h8D7C_6B5A;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic muxed = 1'b0;
    logic rd_ack = 1'b0;
    logic [2:0] straps = 3'h0;
    logic cs_n, rd_n, wr_n, strobe, order_o, b32_o, mux_o, req_valid, req_write;
    logic [12:0] addr_hi;
    logic [13:0] req_addr, aq;
    logic [31:0] data_in, data_out, data_oe, req_wdata, wq;
    wire logic [31:0] rd_data = rd_ack ? CORE_WORD : ~CORE_WORD;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int lat = 0;
    always #12.5 clk_sys = ~clk_sys;
    hbsc_host_port DUT (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr_hi(addr_hi),
        .addr_bit2_or_latch_strobe(strobe), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .byte_order_strap(straps[2]), .width_strap(straps[1]), .bus_mode_strap(straps[0]),
        .cfg_little_endian(order_o), .cfg_bus32(b32_o), .cfg_muxed(mux_o), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rd_ack(rd_ack), .rd_data(rd_data));
    hbsc_host_model host (.clk_sys(clk_sys), .muxed(muxed), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr_hi(addr_hi), .strobe(strobe), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    ////////////////////////////////////////////////////////////////
    // Core side: records each request and answers reads three cycles later
    always @(negedge clk_sys) begin
        // One assignment of the acknowledge per edge, so no glitch reaches the core word
        rd_ack = (lat == 1);
        if (lat != 0) begin
            lat = lat - 1;
        end
        if (req_valid === 1'b1) begin
            aq = req_addr;
            wq = (req_write === 1'b1) ? req_wdata : 32'hFFFF_FFFF;
            if (req_write !== 1'b1) lat = 3;
        end
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Reset with the given straps, then move the straps to show they are held
    task automatic do_reset(input logic [2:0] s);
        @(negedge clk_sys);
        rstn = 1'b0;
        straps = s;
        repeat (4) @(negedge clk_sys);
        check(data_oe | {31'h0, req_valid}, 32'h0);
        rstn = 1'b1;
        @(negedge clk_sys);
        straps = ~s;
        muxed = s[0];
        @(negedge clk_sys);
        check({29'h0, order_o, b32_o, mux_o}, {29'h0, s});
    endtask
    // One word written and one word read in the bus setup chosen by the straps, each as two cycles in 16-bit mode
    task automatic test_rw(input logic [2:0] s);
        logic [31:0] hw, d, d2, oe;
        logic [13:0] wa;
        hw = s[2] ? CORE_WORD : CORE_SWAP;
        do_reset(s);
        wa = s[1] ? 14'h3FFD : 14'h0002;
        if (s[1]) begin
            host.wr(14'h3FFD, HOST_WORD);
        end else begin
            host.wr(14'h3FFD, {16'h0, HOST_WORD[15:0]});
            host.wr(14'h0002, {16'h0, HOST_WORD[31:16]});
        end
        repeat (3) @(negedge clk_sys);
        check({18'h0, aq}, {18'h0, wa});
        check(wq, s[2] ? HOST_WORD : HOST_SWAP);
        host.rd(14'h1554, d, oe);
        d2 = d >> 16;
        if (!s[1]) host.rd(14'h1555, d2, oe);
        check({d2[15:0], d[15:0]}, hw);
        check(oe, s[1] ? LANES_32 : LANES_16);
        check({18'h0, aq}, 32'h0000_1554);
        $display("Test rw straps %b done", s);
    endtask
    task automatic tally_and_finish();
        $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Every strap combination in turn
    initial begin
        for (int i = 0; i < 8; i++) test_rw(3'(i));
        tally_and_finish();
    end
endmodule
`default_nettype wire
